// ---- inc/gpt_pkg.sv ----
`default_nettype none
package gpt_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] GPT_OFF_CONTROL = 8'h00;
  localparam logic [7:0] GPT_OFF_COUNT   = 8'h04;
  localparam logic [7:0] GPT_OFF_PERIOD  = 8'h08;
  localparam logic [7:0] GPT_OFF_STATUS  = 8'h0C;
  // Control register field positions.
  localparam int GPT_BIT_RUN      = 15;
  localparam int GPT_BIT_IDLE     = 13;
  localparam int GPT_BIT_GATE     = 6;
  localparam int GPT_BIT_PS_LO    = 4;
  localparam int GPT_BIT_SYNC     = 2;
  localparam int GPT_BIT_SRC      = 1;
  // Writable bits of the control register; all others read as zero.
  localparam logic [15:0] GPT_CONTROL_MASK  = 16'hA076;
  localparam logic [15:0] GPT_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] GPT_PERIOD_RESET  = 16'hFFFF;
  // Prescale ratios minus one.
  localparam logic [7:0] GPT_DIV1   = 8'h00;
  localparam logic [7:0] GPT_DIV8   = 8'h07;
  localparam logic [7:0] GPT_DIV64  = 8'h3F;
  localparam logic [7:0] GPT_DIV256 = 8'hFF;
  // Width of the irq request pulse, in cycles.
  localparam int GPT_IRQ_PULSE_CYCLES = 1;
endpackage : gpt_pkg
`default_nettype wire

// ---- rtl/gpt_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two flip-flop synchroniser for the external pins.
module gpt_sync2 #(
  parameter int W = 2
) (
  input  wire logic         i_clock,  // system clock
  input  wire logic         i_rst,    // synchronous reset
  input  wire logic [W-1:0] i_async,  // asynchronous pins
  output logic      [W-1:0] o_sync    // synchronised levels
);
  logic [W-1:0] meta_r;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule // gpt_sync2
`default_nettype wire

// ---- rtl/gpt_timer.sv ----
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module gpt_timer
  import gpt_pkg::*;
(
  input  wire logic        i_clock,        // 100 MHz system clock
  input  wire logic        i_rst,          // synchronous reset, active high
  input  wire logic        i_psel,         // APB select
  input  wire logic        i_penable,      // APB enable
  input  wire logic        i_pwrite,       // APB write
  input  wire logic [7:0]  i_paddr,        // APB byte address
  input  wire logic [31:0] i_pwdata,       // APB write data
  input  wire logic        i_idle,         // device in Idle mode
  input  wire logic        i_ext_count_pin,// external clock pin
  input  wire logic        i_gate_pin,     // external gate pin
  output logic             o_pready,       // APB ready
  output logic             o_pslverr,      // APB error on unmapped address
  output logic [31:0]      o_prdata,       // APB read data
  output logic             o_irq,          // interrupt request pulse
  output logic [15:0]      o_count         // current count value
);

  typedef struct packed {
    logic [15:0] control;
    logic [15:0] count;
    logic [15:0] period;
    logic [7:0]  prescale;
    logic        ext_prev;
    logic        gate_prev;
    logic        match_flag;
    logic        gate_flag;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
  } gpt_state_s;

  gpt_state_s st_r;
  gpt_state_s st_nxt;
  logic [1:0] pins_sync;
  logic [1:0] pins_raw;

  assign pins_raw = {i_gate_pin, i_ext_count_pin};

  gpt_sync2 #(
    .W (2)
  ) u_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async (pins_raw),
    .o_sync  (pins_sync)
  );

  function automatic logic [7:0] gpt_div_limit(input logic [1:0] sel);
    case (sel)
      2'b00:   gpt_div_limit = GPT_DIV1;
      2'b01:   gpt_div_limit = GPT_DIV8;
      2'b10:   gpt_div_limit = GPT_DIV64;
      default: gpt_div_limit = GPT_DIV256;
    endcase
  endfunction

  logic        run;
  logic        ext_sel;
  logic        gate_en;
  logic        ext_rise;
  logic        raw_tick;
  logic        match_evt;
  logic        gate_evt;
  logic        wr;
  logic        rd;
  logic [7:0]  div_lim;

  always_comb begin
    run      = st_r.control[GPT_BIT_RUN];
    ext_sel  = st_r.control[GPT_BIT_SRC];
    gate_en  = st_r.control[GPT_BIT_GATE] & ~ext_sel;
    // sync select; both paths use the synchronised pin because this
    // single-clock design cannot count truly asynchronously.
    ext_rise = pins_sync[0] & ~st_r.ext_prev;
    raw_tick = ext_sel ? ext_rise : 1'b1;
    if (gate_en) begin
      raw_tick = pins_sync[1];
    end
    wr       = i_psel & i_penable & i_pwrite & st_r.pready;
    rd       = i_psel & ~i_penable & ~i_pwrite;
    div_lim  = gpt_div_limit(st_r.control[GPT_BIT_PS_LO +: 2]);
  end

  always_comb begin
    st_nxt          = st_r;
    st_nxt.ext_prev = pins_sync[0];
    st_nxt.gate_prev= pins_sync[1];
    st_nxt.irq      = 1'b0;
    st_nxt.pready   = 1'b0;
    st_nxt.pslverr  = 1'b0;
    match_evt       = 1'b0;
    gate_evt        = 1'b0;
    if (run && !(i_idle && st_r.control[GPT_BIT_IDLE]) && raw_tick) begin
      if (st_r.prescale >= div_lim) begin
        st_nxt.prescale = 8'h00;
        if (st_r.count == st_r.period) begin
          st_nxt.count      = 16'h0000;
          st_nxt.match_flag = 1'b1;
          st_nxt.irq        = 1'b1;
          match_evt         = 1'b1;
        end else begin
          st_nxt.count = st_r.count + 16'h0001;
        end
      end else begin
        st_nxt.prescale = st_r.prescale + 8'h01;
      end
    end
    if (run && gate_en && st_r.gate_prev && !pins_sync[1]) begin
      st_nxt.gate_flag = 1'b1;
      st_nxt.irq       = 1'b1;
      gate_evt         = 1'b1;
    end
    // APB: setup cycle prepares data, access phase completes in one cycle.
    if (i_psel && !i_penable) begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = 32'h0000_0000;
      case (i_paddr)
        GPT_OFF_CONTROL: st_nxt.prdata = {16'h0000, st_r.control};
        GPT_OFF_COUNT:   st_nxt.prdata = {16'h0000, st_r.count};
        GPT_OFF_PERIOD:  st_nxt.prdata = {16'h0000, st_r.period};
        GPT_OFF_STATUS:  st_nxt.prdata = {30'h0, st_r.gate_flag, st_r.match_flag};
        default:         st_nxt.pslverr = 1'b1;
      endcase
      if (!rd) begin
        st_nxt.prdata = st_r.prdata;
      end
    end
    if (wr) begin
      case (i_paddr)
        GPT_OFF_CONTROL: st_nxt.control = i_pwdata[15:0] & GPT_CONTROL_MASK;
        GPT_OFF_COUNT: begin
          if (!(ext_sel && run)) begin
            st_nxt.count = i_pwdata[15:0];
          end
        end
        GPT_OFF_PERIOD: st_nxt.period = i_pwdata[15:0];
        // Write one to clear; a same-cycle event still wins.
        GPT_OFF_STATUS: begin
          st_nxt.match_flag = (st_r.match_flag & ~i_pwdata[0]) | match_evt;
          st_nxt.gate_flag  = (st_r.gate_flag & ~i_pwdata[1]) | gate_evt;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_r <= '{control: GPT_CONTROL_RESET, count: 16'h0000, period: GPT_PERIOD_RESET,
                prescale: 8'h00, prdata: 32'h0000_0000, default: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_pready  = st_r.pready;
  assign o_pslverr = st_r.pslverr;
  assign o_prdata  = st_r.prdata;
  assign o_irq     = st_r.irq;
  assign o_count   = st_r.count;

endmodule // gpt_timer
`default_nettype wire

// ---- testbench/gpt_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpt_chk (
  input wire logic        i_clock,   // clock
  input wire logic        i_rst,     // reset
  input wire logic        i_psel,    // select
  input wire logic        i_penable, // enable
  input wire logic [7:0]  i_paddr,   // address
  input wire logic        o_pready,  // ready
  input wire logic        o_pslverr, // error
  input wire logic        o_irq,     // irq
  input wire logic [15:0] o_count    // count
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  setup_ready_a:
    assert property (i_psel && !i_penable |=> o_pready) else $error("ready late");
  ready_cause_a:
    assert property (!(i_psel && !i_penable) |=> !o_pready) else $error("stray ready");
  bad_addr_a:
    assert property (i_psel && !i_penable && i_paddr > 8'h0C |=> o_pslverr) else $error("no err");
  good_addr_a:
    assert property (i_psel && !i_penable && i_paddr == 8'h04 |=> !o_pslverr) else $error("err");
  err_ready_a:
    assert property (o_pslverr |-> o_pready) else $error("lone err");
  irq_pulse_a:
    assert property (o_irq |=> !o_irq) else $error("long irq");
  count_step_a:
    assert property (!$past(i_psel) && o_count != $past(o_count) |->
      o_count == $past(o_count) + 16'h0001 || o_count == 16'h0000) else $error("bad step");
  count_rst_a:
    assert property (disable iff (1'b0) i_rst |=> o_count == 16'h0000 && !o_irq)
      else $error("reset");
endmodule // gpt_chk
bind gpt_timer gpt_chk chk_u (.i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_irq(o_irq), .o_count(o_count));
`default_nettype wire

// ---- testbench/gpt_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpt_pin_model (
  input  wire logic i_clock, // clock
  output logic      o_ext,   // count pin
  output logic      o_gate   // gate pin
);
  initial begin
    o_ext = 1'b0;
    o_gate = 1'b0;
  end
  // rising edges counted; a long hold models a slow source.
  task automatic pulse(input int n, input int hold);
    repeat (n) begin
      o_ext <= 1'b1;
      repeat (hold) @(posedge i_clock);
      o_ext <= 1'b0;
      repeat (hold) @(posedge i_clock);
    end
  endtask
  task automatic gate(input logic v);
    o_gate <= v;
  endtask
endmodule // gpt_pin_model
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  import gpt_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, idle = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, s;
  logic        ready, err, perr, irq, ext, gate;
  logic [15:0] count;
  int          fail_count = 0, n_checks = 0, c;
  gpt_timer dut_u (.i_clock(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_idle(idle), .i_ext_count_pin(ext),
    .i_gate_pin(gate), .o_pready(ready), .o_pslverr(err), .o_prdata(prdata), .o_irq(irq),
    .o_count(count));
  gpt_pin_model pin_u (.i_clock(clk), .o_ext(ext), .o_gate(gate));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (ready !== 1'b1);
    q = prdata;
    perr = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_irq;
    c = 0;
    do begin @(posedge clk); c++; end while (irq !== 1'b1 && c < 3000);
  endtask
  task automatic t_regs;
    apb(0, GPT_OFF_CONTROL, 0); `CHK(q, 32'h0000_0000)
    apb(0, GPT_OFF_PERIOD, 0); `CHK(q, 32'h0000_FFFF)
    apb(1, GPT_OFF_CONTROL, 32'hFFFF_5F89); apb(0, GPT_OFF_CONTROL, 0); `CHK(q, 32'h0)
    apb(0, 8'h10, 0); `CHK(perr, 1'b1)
    $display("regs done");
  endtask
  task automatic t_timer;
    int div [4] = '{1, 8, 64, 256};
    for (int p = 0; p < 4; p++) begin
      // count, period and mode first, run last.
      apb(1, GPT_OFF_COUNT, 0);
      apb(1, GPT_OFF_PERIOD, 2);
      apb(1, GPT_OFF_CONTROL, p << 4);
      apb(1, GPT_OFF_CONTROL, 32'h8000 | (p << 4));
      wait_irq;
      wait_irq; `CHK(c, 3 * div[p])
    end
    apb(1, GPT_OFF_CONTROL, 0); apb(0, GPT_OFF_COUNT, 0); s = q;
    repeat (20) @(posedge clk);
    apb(0, GPT_OFF_COUNT, 0); `CHK(q, s)
    `CHK(count, s[15:0])
    $display("timer done");
  endtask
  task automatic t_idle;
    apb(1, GPT_OFF_PERIOD, 32'hFFFF); apb(1, GPT_OFF_COUNT, 0);
    idle <= 1'b1;
    apb(1, GPT_OFF_CONTROL, 32'hA000); repeat (20) @(posedge clk);
    apb(0, GPT_OFF_COUNT, 0); `CHK(q, 32'h0)
    apb(1, GPT_OFF_CONTROL, 32'h8000); apb(0, GPT_OFF_COUNT, 0); `CHK(q > 0, 1'b1)
    idle <= 1'b0;
    apb(1, GPT_OFF_CONTROL, 0);
    $display("idle done");
  endtask
  task automatic t_ext;
    for (int y = 0; y < 2; y++) begin
      // Gate bit set and gate low: an external source must still count.
      apb(1, GPT_OFF_COUNT, 0); apb(1, GPT_OFF_CONTROL, 32'h8042 | (y << 2));
      pin_u.pulse(5, 2 + 3 * y);
      repeat (4) @(posedge clk);
      apb(0, GPT_OFF_COUNT, 0); `CHK(q, 32'h5)
      apb(1, GPT_OFF_COUNT, 32'h1234); apb(0, GPT_OFF_COUNT, 0); `CHK(q, 32'h5)
      apb(1, GPT_OFF_CONTROL, 0);
    end
    $display("ext done");
  endtask
  task automatic t_gate;
    apb(1, GPT_OFF_COUNT, 0); apb(1, GPT_OFF_CONTROL, 32'h8040); repeat (10) @(posedge clk);
    apb(0, GPT_OFF_COUNT, 0); `CHK(q, 32'h0)
    pin_u.gate(1'b1); repeat (10) @(posedge clk);
    pin_u.gate(1'b0); wait_irq; `CHK(c < 8, 1'b1)
    apb(0, GPT_OFF_STATUS, 0); `CHK(q, 32'h0000_0003)
    apb(1, GPT_OFF_STATUS, 32'h0000_0003); apb(0, GPT_OFF_STATUS, 0); `CHK(q, 32'h0)
    apb(0, GPT_OFF_COUNT, 0); s = q; `CHK(s > 0, 1'b1)
    repeat (10) @(posedge clk);
    apb(0, GPT_OFF_COUNT, 0); `CHK(q, s)
    $display("gate done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs; t_timer; t_idle; t_ext; t_gate;
    print_verdict;
  end
  initial begin
    #300us;
    fail_count++;
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
